// file: rtl/cskip_map.svh
// Opcode fields, address constants and phase codes of the compare-and-skip logic.
`ifndef CSKIP_MAP_SVH
`define CSKIP_MAP_SVH

// Upper seven opcode bits of the three compare instructions.
`define CSK_OPC_LESS    7'h30
`define CSK_OPC_EQUAL   7'h31
`define CSK_OPC_GREATER 7'h32

// Instruction word fields.
`define CSK_OPC_MSB     15
`define CSK_OPC_LSB     9
`define CSK_ACC_BIT     8
`define CSK_FLD_MSB     7
`define CSK_FLD_LSB     0

// Access bank split and indexed literal offset limit.
`define CSK_IDX_MAX     8'h5F
`define CSK_ACC_LOW     4'h0
`define CSK_ACC_HIGH    4'hF

// One-hot quarter phase codes.
`define CSK_PH_Q1       4'h1
`define CSK_PH_Q2       4'h2
`define CSK_PH_Q3       4'h4
`define CSK_PH_Q4       4'h8

// One-hot execution state codes.
`define CSK_ST_IDLE     4'h1
`define CSK_ST_EXEC     4'h2
`define CSK_ST_SKIP1    4'h4
`define CSK_ST_SKIP2    4'h8

`endif

// file: rtl/cskip_pkg.sv
// Types shared by the compare-and-skip execution logic.
`default_nettype none
`include "cskip_map.svh"
package cskip_pkg;

  typedef enum logic [3:0] {
    PH_Q1 = `CSK_PH_Q1,
    PH_Q2 = `CSK_PH_Q2,
    PH_Q3 = `CSK_PH_Q3,
    PH_Q4 = `CSK_PH_Q4
  } phase_type;

  typedef enum logic [3:0] {
    ST_IDLE  = `CSK_ST_IDLE,
    ST_EXEC  = `CSK_ST_EXEC,
    ST_SKIP1 = `CSK_ST_SKIP1,
    ST_SKIP2 = `CSK_ST_SKIP2
  } state_type;

  typedef enum logic [1:0] {
    CMP_LESS    = 2'h0,
    CMP_EQUAL   = 2'h1,
    CMP_GREATER = 2'h2
  } cmp_type;

  typedef struct packed {
    phase_type ph;
  } phase_state_type;

  typedef struct packed {
    state_type   st;
    cmp_type     kind;
    logic [11:0] addr;
    logic [7:0]  w;
    logic        rd;
    logic        skip;
    logic        two_word;
    logic        discard;
    logic        nop;
    logic        done;
    logic        wr;
    logic        swr;
    logic        busy;
  } exec_type;

endpackage
`default_nettype wire

// file: rtl/phase_if.sv
// Quarter phase signals passed from the phase divider to the executor.
`timescale 1ns/1ps
`default_nettype none
interface phase_if;
  cskip_pkg::phase_type ph;
  modport gen (output ph);
  modport sink (input ph);
endinterface
`default_nettype wire

// file: rtl/quarter_phase_gen.sv
// Divider that walks the four quarter phases of an instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module quarter_phase_gen (
  input  wire logic clk_sys,
  input  wire logic srst,
  phase_if.gen      phase
);
  import cskip_pkg::*;

  phase_state_type s_q;
  phase_state_type s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.ph)
      PH_Q1:   s_d.ph = PH_Q2;
      PH_Q2:   s_d.ph = PH_Q3;
      PH_Q3:   s_d.ph = PH_Q4;
      PH_Q4:   s_d.ph = PH_Q1;
      default: s_d.ph = PH_Q1;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q.ph <= PH_Q1;
    end else begin
      s_q <= s_d;
    end
  end

  assign phase.ph = s_q.ph;

endmodule
`default_nettype wire

// file: rtl/compare_skip_exec.sv
// Executor for the compare-and-skip instructions with skip cycle control.
`timescale 1ns/1ps
`default_nettype none
`include "cskip_map.svh"
module compare_skip_exec (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic                 instr_valid,
  input  wire logic [15:0]          instr_word,
  input  wire logic                 next_two_word,
  input  wire logic                 ext_set_en,
  input  wire logic [3:0]           bank_select_reg,
  input  wire logic [11:0]          index_base,
  input  wire logic [7:0]           working_reg_alias,
  input  wire logic [7:0]           mem_rdata,
  output logic [11:0]               mem_addr,
  output logic                      mem_rd_en,
  output logic                      mem_wr_en,
  output logic                      status_wr_en,
  output logic                      compare_busy,
  output logic                      skip_taken,
  output logic                      discard_fetch,
  output logic                      nop_cycle,
  output logic                      cycle_done,
  output cskip_pkg::state_type      exec_state
);
  import cskip_pkg::*;

  phase_if phase ();

  quarter_phase_gen u_phase (
    .clk_sys (clk_sys),
    .srst    (srst),
    .phase   (phase)
  );

  exec_type    s_q;
  exec_type    s_d;
  logic        take;
  cmp_type     kind_n;
  logic [11:0] addr_n;
  logic [8:0]  diff;
  logic [7:0]  fld;

  always_comb begin
    take   = 1'b0;
    kind_n = CMP_LESS;
    addr_n = 12'h000;
    fld    = instr_word[`CSK_FLD_MSB:`CSK_FLD_LSB];
    s_d    = s_q;
    s_d.rd      = 1'b0;
    s_d.discard = 1'b0;
    s_d.done    = 1'b0;
    case (instr_word[`CSK_OPC_MSB:`CSK_OPC_LSB])
      `CSK_OPC_EQUAL: begin
        take   = instr_valid;
        kind_n = CMP_EQUAL;
      end
      `CSK_OPC_GREATER: begin
        take   = instr_valid;
        kind_n = CMP_GREATER;
      end
      `CSK_OPC_LESS: begin
        take   = instr_valid;
        kind_n = CMP_LESS;
      end
      default: begin
        take   = 1'b0;
        kind_n = CMP_LESS;
      end
    endcase
    if (instr_word[`CSK_ACC_BIT]) begin
      addr_n = {bank_select_reg, fld};
    end else if (ext_set_en && (fld <= `CSK_IDX_MAX)) begin
      addr_n = index_base + {4'h0, fld};
    end else if (fld <= `CSK_IDX_MAX) begin
      addr_n = {`CSK_ACC_LOW, fld};
    end else begin
      addr_n = {`CSK_ACC_HIGH, fld};
    end
    diff = {1'b0, mem_rdata} - {1'b0, s_q.w};
    case (s_q.st)
      ST_IDLE: begin
        if ((phase.ph == PH_Q1) && take) begin
          s_d.st   = ST_EXEC;
          s_d.kind = kind_n;
          s_d.addr = addr_n;
          s_d.w    = working_reg_alias;
          s_d.rd   = 1'b1;
          s_d.skip = 1'b0;
        end
      end
      ST_EXEC: begin
        if (phase.ph == PH_Q3) begin
          case (s_q.kind)
            CMP_EQUAL:   s_d.skip = (diff == 9'h000);
            CMP_GREATER: s_d.skip = !diff[8] && (diff[7:0] != 8'h00);
            CMP_LESS:    s_d.skip = diff[8];
            default:     s_d.skip = 1'b0;
          endcase
        end
        if (phase.ph == PH_Q4) begin
          s_d.done     = 1'b1;
          s_d.two_word = next_two_word;
          if (s_q.skip) begin
            s_d.st      = ST_SKIP1;
            s_d.discard = 1'b1;
            s_d.nop     = 1'b1;
          end else begin
            s_d.st = ST_IDLE;
          end
        end
      end
      ST_SKIP1: begin
        if (phase.ph == PH_Q4) begin
          if (s_q.two_word) begin
            s_d.st = ST_SKIP2;
          end else begin
            s_d.st  = ST_IDLE;
            s_d.nop = 1'b0;
          end
        end
      end
      ST_SKIP2: begin
        if (phase.ph == PH_Q4) begin
          s_d.st  = ST_IDLE;
          s_d.nop = 1'b0;
        end
      end
      default: begin
        s_d.st  = ST_IDLE;
        s_d.nop = 1'b0;
      end
    endcase
    s_d.wr  = 1'b0;
    s_d.swr = 1'b0;
    // Busy is registered so that the port comes straight from a flip-flop.
    s_d.busy = (s_d.st != ST_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q.st       <= ST_IDLE;
      s_q.kind     <= CMP_LESS;
      s_q.addr     <= 12'h000;
      s_q.w        <= 8'h00;
      s_q.rd       <= 1'b0;
      s_q.skip     <= 1'b0;
      s_q.two_word <= 1'b0;
      s_q.discard  <= 1'b0;
      s_q.nop      <= 1'b0;
      s_q.done     <= 1'b0;
      s_q.wr       <= 1'b0;
      s_q.swr      <= 1'b0;
      s_q.busy     <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // The memory answers one clock after the read strobe, so the byte is
  // compared in Q3 against the working register captured at decode time.
  assign mem_addr      = s_q.addr;
  assign mem_rd_en     = s_q.rd;
  assign mem_wr_en     = s_q.wr;
  assign status_wr_en  = s_q.swr;
  assign compare_busy  = s_q.busy;
  assign skip_taken    = s_q.skip;
  assign discard_fetch = s_q.discard;
  assign nop_cycle     = s_q.nop;
  assign cycle_done    = s_q.done;
  assign exec_state    = s_q.st;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_EQUAL_SKIP: assert property (
    (phase.ph == PH_Q3) && (s_q.st == ST_EXEC) && (s_q.kind == CMP_EQUAL)
    |=> (skip_taken == ($past(mem_rdata) == s_q.w)))
    else $error("equal compare gave wrong skip");

  AST_GREATER_SKIP: assert property (
    (phase.ph == PH_Q3) && (s_q.st == ST_EXEC) && (s_q.kind == CMP_GREATER)
    |=> (skip_taken == ($past(mem_rdata) > s_q.w)))
    else $error("greater compare gave wrong skip");

  AST_LESS_SKIP: assert property (
    (phase.ph == PH_Q3) && (s_q.st == ST_EXEC) && (s_q.kind == CMP_LESS)
    |=> (skip_taken == ($past(mem_rdata) < s_q.w)))
    else $error("less compare gave wrong skip");

  AST_UNSIGNED: assert property (
    (phase.ph == PH_Q3) && (s_q.st == ST_EXEC) && (s_q.kind == CMP_GREATER)
    && mem_rdata[7] && !s_q.w[7] |=> skip_taken)
    else $error("compare is not unsigned");

  AST_NOP_SPAN: assert property (
    $rose(nop_cycle) |-> discard_fetch ##0 (nop_cycle && !mem_rd_en) [*4])
    else $error("skip cycle not idle for four phases");

  AST_CYCLES_SHORT: assert property (
    discard_fetch && !s_q.two_word |-> nop_cycle [*4] ##1 !nop_cycle)
    else $error("one-word skip not one cycle");

  AST_CYCLES_LONG: assert property (
    discard_fetch && s_q.two_word |-> nop_cycle [*8] ##1 !nop_cycle)
    else $error("two-word skip not two cycles");

  AST_NO_SKIP_TIME: assert property (
    (s_q.st == ST_IDLE) && (phase.ph == PH_Q1) && take
    |=> compare_busy [*3] ##1 (cycle_done && (!skip_taken == !compare_busy)))
    else $error("compare cycle length wrong");

  AST_BANK_ADDR: assert property (
    (s_q.st == ST_IDLE) && (phase.ph == PH_Q1) && take && instr_word[`CSK_ACC_BIT]
    |=> mem_addr == {$past(bank_select_reg), $past(fld)})
    else $error("banked address wrong");

  AST_INDEX_ADDR: assert property (
    (s_q.st == ST_IDLE) && (phase.ph == PH_Q1) && take && !instr_word[`CSK_ACC_BIT]
    && ext_set_en && (fld <= `CSK_IDX_MAX)
    |=> mem_addr == ($past(index_base) + {4'h0, $past(fld)}))
    else $error("indexed address wrong");

  AST_NO_WRITE: assert property (
    !mem_wr_en && !status_wr_en)
    else $error("compare wrote memory or flags");

  AST_READ_PHASE: assert property (
    mem_rd_en |-> (phase.ph == PH_Q2) && (s_q.st == ST_EXEC))
    else $error("read outside Q2");

  COV_NO_SKIP: cover property (cycle_done && !skip_taken);
  COV_SKIP_ONE: cover property (discard_fetch && !s_q.two_word);
  COV_SKIP_TWO: cover property (discard_fetch && s_q.two_word);
  COV_INDEXED: cover property (take && ext_set_en && !instr_word[`CSK_ACC_BIT]);

endmodule
`default_nettype wire

// file: verif/test_compare_skip_exec.sv
// Self-checking bench for the compare-and-skip executor.
`timescale 1ns/1ps
`default_nettype none
module test_compare_skip_exec;
  import cskip_pkg::*;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic        next_two_word = 1'b0;
  logic        ext_set_en = 1'b0;
  logic [3:0]  bank_select_reg = 4'h0;
  logic [11:0] index_base = 12'h000;
  logic [7:0]  working_reg_alias = 8'h00;
  logic [7:0]  mem_rdata = 8'h00;
  logic [11:0] mem_addr;
  logic        mem_rd_en, mem_wr_en, status_wr_en, compare_busy;
  logic        skip_taken, discard_fetch, nop_cycle, cycle_done;
  state_type   exec_state;
  int          err_count = 0;
  int          check_count = 0;
  int          rd_seen = 0;
  logic        hung = 1'b0;
  logic [31:0] rng = 32'h9326C541;
  logic [7:0]  cm [4] = '{8'h00, 8'hFF, 8'h80, 8'h5A};
  logic [7:0]  cw [4] = '{8'hFF, 8'h00, 8'h7F, 8'h5A};

  compare_skip_exec compare_skip_exec_inst (.clk_sys, .srst, .instr_valid, .instr_word,
    .next_two_word, .ext_set_en, .bank_select_reg, .index_base, .working_reg_alias,
    .mem_rdata, .mem_addr, .mem_rd_en, .mem_wr_en, .status_wr_en, .compare_busy,
    .skip_taken, .discard_fetch, .nop_cycle, .cycle_done, .exec_state);

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [11:0] exp_addr(input logic a, input logic [7:0] f);
    if (a) return {bank_select_reg, f};
    if (ext_set_en && f <= 8'h5F) return index_base + {4'h0, f};
    return (f <= 8'h5F) ? {4'h0, f} : {4'hF, f};
  endfunction

  function automatic logic exp_skip(input logic [1:0] k, input logic [7:0] m,
      input logic [7:0] w);
    case (k)
      2'h0: return m < w;
      2'h1: return m == w;
      default: return m > w;
    endcase
  endfunction

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Neither memory nor flags may ever be written by a compare.
  always @(posedge clk_sys) begin
    if (mem_rd_en === 1'b1) rd_seen++;
    if (!srst) check("write_enables", 0, {mem_wr_en, status_wr_en});
  end

  task automatic run(input logic [1:0] k, input logic a, input logic [7:0] f,
      input logic [7:0] w, input logic [7:0] m, input logic two);
    logic sk;
    int   n;
    int   blen;
    int   nops;
    sk = exp_skip(k, m, w);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= {7'h30 + 7'(k), a, f};
    working_reg_alias <= w;
    mem_rdata <= m;
    next_two_word <= two;
    rd_seen = 0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (compare_busy !== 1'b1 && n < 8);
    check("taken", 1, compare_busy);
    // A request that is never taken stops the random runs; the refusal checks and the closing report follow.
    if (compare_busy !== 1'b1) begin
      hung = 1'b1;
      return;
    end
    check("mem_rd_en", 1, mem_rd_en);
    check("mem_addr", exp_addr(a, f), mem_addr);
    blen = 1;
    nops = 0;
    for (int i = 0; i < 12 && compare_busy === 1'b1; i++) begin
      @(posedge clk_sys);
      if (i == 0) instr_valid <= 1'b0;
      #1;
      if (cycle_done === 1'b1) begin
        check("done_delay", 4, blen + 1);
        check("skip_taken", sk, skip_taken);
        check("discard_fetch", sk, discard_fetch);
        check("exec_state", sk ? ST_SKIP1 : ST_IDLE, exec_state);
      end
      if (nop_cycle === 1'b1) nops++;
      if (compare_busy === 1'b1) blen++;
    end
    check("busy_cycles", sk ? (two ? 11 : 7) : 3, blen);
    check("nop_clocks", sk ? (two ? 8 : 4) : 0, nops);
    check("rd_pulses", 1, rd_seen);
  endtask

  // Opcodes outside the three compares must neither raise busy nor strobe a read.
  task automatic refuse(input logic [15:0] word);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= word;
    rd_seen = 0;
    repeat (8) @(posedge clk_sys);
    #1;
    check("refused_busy", 0, compare_busy);
    check("refused_rd", 0, rd_seen);
    @(posedge clk_sys) instr_valid <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    check("reset_state", ST_IDLE, exec_state);
    check("reset_addr", 0, mem_addr);
    check("reset_flags", 0, {compare_busy, skip_taken, nop_cycle, cycle_done});
    for (int i = 0; i < 60 && !hung; i++) begin
      rng = xs(rng);
      @(posedge clk_sys);
      ext_set_en <= rng[0];
      bank_select_reg <= rng[4:1];
      index_base <= rng[16:5];
      rng = xs(rng);
      // Boundary byte pairs and both sides of the offset limit come first.
      if (i < 12) run(2'(i % 3), i[1], i[0] ? 8'h60 : 8'h5F, cw[i / 3], cm[i / 3], i[2]);
      else run(rng[1:0] == 2'h3 ? 2'h1 : rng[1:0], rng[4], rng[31:24],
               rng[3] ? rng[15:8] : rng[23:16], rng[15:8], rng[5]);
    end
    refuse(16'h6A00);
    refuse(16'h6600);
    refuse(16'h1E00);
    print_verdict();
  end
endmodule
`default_nettype wire
